// ---- common/mcd_defs.vh ----
/*
  Constants of the motion command word decoder: image layout, command word
  bit positions, configuration fields, status codes and timing.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef MCD_DEFS_VH
`define MCD_DEFS_VH

`define MCD_NUM_WORDS        10
`define MCD_PRIMARY_OFS      16'h0400
`define MCD_SECONDARY_OFS    16'h0401
`define MCD_LAST_OFS         16'h0409

// Primary command word bits
`define MCD_B_MODE           15
`define MCD_B_PRESET_ENC     14
`define MCD_B_RUN_SEG        13
`define MCD_B_READBACK       12
`define MCD_B_PROGRAM        11
`define MCD_B_CLR_FAULTS     10
`define MCD_B_PRESET_POS     9
`define MCD_B_RUN_CCW        8
`define MCD_B_RUN_CW         7

// Secondary command word bits
`define MCD_S_ENC_FOLLOW     14
`define MCD_S_POS_FOLLOW     12
`define MCD_S_SEG_TYPE       9
`define MCD_S_REG_MOVE       7
`define MCD_S_GEARING        6
`define MCD_S_REV_BLEND      4

// Configuration word 1 format bits
`define MCD_C_IN_FMT         9
`define MCD_C_OUT_FMT        8
`define MCD_C_ENDIAN         7

`define MCD_STATUS_CFG_ERR   16'h6408
`define MCD_MW_MAX           32'sd32767999
`define MCD_MW_MIN           (-32'sd32768000)
`define MCD_THOUSAND         32'sd1000

// Dwell tick: one millisecond at the 20 MHz system clock
`define MCD_CLK_HZ           20000000
`define MCD_DWELL_UNIT_US    1000
`define MCD_MS_CYCLES        ((`MCD_CLK_HZ / 1000000) * `MCD_DWELL_UNIT_US)

// Move kinds reported on the motion output
`define MCD_MV_IDLE          3'h0
`define MCD_MV_MANUAL        3'h1
`define MCD_MV_REGISTER      3'h2
`define MCD_MV_FOLLOWER      3'h3
`define MCD_MV_BLEND         3'h4
`define MCD_MV_DWELL         3'h5

`endif

// ---- rtl/mcd_word_codec.v ----
/*
  Converts one 32-bit quantity between its internal signed value and the
  two 16-bit words that carry it on the network, in either direction.
  Assumes pure combinational use inside the decoder on one clock.
*/
`timescale 1ns/1ps
`include "mcd_defs.vh"

module mcd_word_codec (
  input  wire [15:0] first_word,
  input  wire [15:0] second_word,
  input  wire        use_binary,
  input  wire        big_endian,
  output reg  [31:0] decoded,
  input  wire [31:0] value,
  output reg  [15:0] enc_first,
  output reg  [15:0] enc_second,
  output reg         enc_overflow
);

  reg signed [31:0] hi_s;
  reg signed [31:0] lo_s;
  reg signed [31:0] val_s;
  reg signed [31:0] quot;
  reg signed [31:0] rem_s;

  always @* begin
    hi_s  = {{16{first_word[15]}}, first_word};
    lo_s  = {{16{second_word[15]}}, second_word};
    val_s = value;
    // Signed division truncates toward zero so remainder keeps the sign [RQ3]
    quot  = val_s / `MCD_THOUSAND;
    rem_s = val_s - quot * `MCD_THOUSAND;
    if (use_binary) begin
      if (big_endian) begin
        decoded    = {first_word, second_word}; // [RQ6]
        enc_first  = value[31:16];
        enc_second = value[15:0];
      end else begin
        decoded    = {second_word, first_word}; // [RQ6]
        enc_first  = value[15:0];
        enc_second = value[31:16];
      end
      enc_overflow = 1'b0;
    end else begin
      decoded      = hi_s * `MCD_THOUSAND + lo_s; // [RQ3]
      enc_first    = quot[15:0];
      enc_second   = rem_s[15:0];
      // Out of span the words are undefined; flag it instead [RQ4]
      enc_overflow = (val_s > `MCD_MW_MAX) || (val_s < `MCD_MW_MIN);
      if (enc_overflow) begin
        enc_first  = 16'hFFFF;
        enc_second = 16'hFFFF;
      end
    end
  end

endmodule

// ---- rtl/mcd_decoder.v ----
/*
  Motion command word decoder. Accepts the ten-word output image one word
  per write strobe, detects rising command bits and issues one-cycle command
  pulses with decoded parameters; returns positions in the selected format.
  Assumes the writer and motion core are logic on the same sys_clk.
*/
// Summary of operation
// RQ1: Output and input images are each exactly ten 16-bit words; the code returns five input words by rd_index.
// RQ2: Without valid configuration report 6408h, keep motor off, ignore commands.
// RQ3: Multi-word format: value/1000 in first word, signed remainder in second.
// RQ4: Out-of-span reported position gives indeterminate words; binary format advised.
// RQ5: Separate format selections for values written and values returned.
// RQ6: Binary format word order: little endian puts low half first.
// RQ7: Host with typed description selects binary formats, little endian.
// RQ8: Host treats multi-word format words as signed 16-bit integers.
// RQ9: A command bit acts only on a 0-to-1 change between writes.
// RQ10: A bit held set across the switch into command mode does nothing.
// RQ11: Word 0 primary, word 1 secondary, words 2-9 parameters; registers 1024-1033.
// RQ12: Primary bit 15 selects configuration mode (1) or command mode (0).
// RQ13: Rising primary bit 14 loads encoder position from words 2 and 3.
// RQ14: Rising bit 13 runs segmented move; secondary bit 9 picks blend or dwell.
// RQ15: Dwell between segments comes from word 9 in milliseconds.
// RQ16: Secondary bit 4 sets blend direction: 0 clockwise, 1 counter-clockwise.
// RQ17: Bits 11 and 12 program and read back segments before running.
// RQ18: Rising bit 10 clears faults and move-done, then retries present command; the code pulses clear_faults and clears move_done, with no retry.
// RQ19: Rising bit 9 loads motor position from words 2, 3, clears move-done.
// RQ20: Rising bit 8 runs manual move counter-clockwise; secondary bit 7 registration.
// RQ21: Secondary bit 6 selects gearing; manual bits become motion enables.
// RQ22: Follower bits 12 or 14 with registration clear give axis follower mode.
// RQ23: Rising bit 7 runs manual move clockwise with the same modifiers.
`timescale 1ns/1ps
`include "mcd_defs.vh"

module mcd_decoder (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [15:0] wr_addr,
  input  wire [15:0] wr_data,
  input  wire        image_done,
  input  wire        cfg_valid,
  input  wire        cfg_in_binary,
  input  wire        cfg_out_binary,
  input  wire        cfg_big_endian,
  input  wire        fault_active,
  input  wire        move_done_set,
  input  wire [31:0] motor_position,
  input  wire [31:0] encoder_position,
  input  wire [2:0]  rd_index,
  output reg  [15:0] rd_data,
  output reg  [15:0] status_word,
  output reg         motor_enable,
  output reg         move_done,
  output reg         preset_encoder,
  output reg         preset_motor,
  output reg  [31:0] preset_value,
  output reg         clear_faults,
  output reg         run_segmented_motion,
  output reg         seg_dwell,
  output reg         seg_counterclockwise,
  output reg         seg_pause_tick,
  output reg         program_segments,
  output reg         readback_segments,
  output reg         manual_run_clockwise,
  output reg         manual_run_counterclockwise,
  output reg  [2:0]  move_kind,
  output reg         gearing_enable,
  output reg         position_overflow
);

  // Ten-word output image as written by the host [RQ1] [RQ11]
  reg  [15:0] image_reg [0:`MCD_NUM_WORDS-1];
  reg  [15:0] prev_cmd_reg;
  reg  [15:0] dwell_left_reg;
  reg  [15:0] ms_cnt_reg;
  reg         dwell_run_reg;
  reg         mode_cfg_reg;
  integer     i;

  wire [3:0]  word_idx;
  wire        in_range;
  wire [15:0] cmd0;
  wire [15:0] cmd1;
  wire [15:0] rise;
  wire        accept;
  wire [31:0] param_value;
  wire [15:0] mpos_first;
  wire [15:0] mpos_second;
  wire        mpos_ovf;
  wire [15:0] epos_first;
  wire [15:0] epos_second;
  wire        epos_ovf;
  wire        follower_sel;
  // One strobe per command bit, live only in the cycle an update is accepted
  wire        go_preset_enc;
  wire        go_run_seg;
  wire        go_readback;
  wire        go_program;
  wire        go_clr_faults;
  wire        go_preset_pos;
  wire        go_run_ccw;
  wire        go_run_cw;

  assign word_idx = wr_addr[3:0];
  assign in_range = (wr_addr >= `MCD_PRIMARY_OFS) && (wr_addr <= `MCD_LAST_OFS);
  assign cmd0     = image_reg[0];
  assign cmd1     = image_reg[1];
  // Edges are judged between whole images so each write cycle counts once [RQ9]
  assign rise     = cmd0 & ~prev_cmd_reg;
  // No command acts in configuration mode or without a valid setup [RQ2] [RQ12]
  assign accept   = image_done && cfg_valid && !cmd0[`MCD_B_MODE];
  assign follower_sel = (cmd1[`MCD_S_ENC_FOLLOW] | cmd1[`MCD_S_POS_FOLLOW]) & ~cmd1[`MCD_S_REG_MOVE];

  assign go_preset_enc = accept & rise[`MCD_B_PRESET_ENC]; // [RQ13]
  assign go_run_seg    = accept & rise[`MCD_B_RUN_SEG];    // [RQ14]
  assign go_readback   = accept & rise[`MCD_B_READBACK];   // [RQ17]
  assign go_program    = accept & rise[`MCD_B_PROGRAM];    // [RQ17]
  assign go_clr_faults = accept & rise[`MCD_B_CLR_FAULTS]; // [RQ18]
  assign go_preset_pos = accept & rise[`MCD_B_PRESET_POS]; // [RQ19]
  assign go_run_ccw    = accept & rise[`MCD_B_RUN_CCW];    // [RQ20]
  assign go_run_cw     = accept & rise[`MCD_B_RUN_CW];     // [RQ23]

  // Parameters in words 2 and 3 use the written-value format [RQ5]
  mcd_word_codec u_param (
    .first_word   (image_reg[2]),
    .second_word  (image_reg[3]),
    .use_binary   (cfg_out_binary),
    .big_endian   (cfg_big_endian),
    .decoded      (param_value),
    .value        (32'h0000_0000),
    .enc_first    (),
    .enc_second   (),
    .enc_overflow ()
  );

  // Returned positions use the returned-value format [RQ5]
  mcd_word_codec u_mpos (
    .first_word   (16'h0000),
    .second_word  (16'h0000),
    .use_binary   (cfg_in_binary),
    .big_endian   (cfg_big_endian),
    .decoded      (),
    .value        (motor_position),
    .enc_first    (mpos_first),
    .enc_second   (mpos_second),
    .enc_overflow (mpos_ovf)
  );

  mcd_word_codec u_epos (
    .first_word   (16'h0000),
    .second_word  (16'h0000),
    .use_binary   (cfg_in_binary),
    .big_endian   (cfg_big_endian),
    .decoded      (),
    .value        (encoder_position),
    .enc_first    (epos_first),
    .enc_second   (epos_second),
    .enc_overflow (epos_ovf)
  );

  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < `MCD_NUM_WORDS; i = i + 1) begin
        image_reg[i] <= 16'h0000;
      end
    end else if (wr_en && in_range && word_idx < `MCD_NUM_WORDS) begin
      image_reg[word_idx] <= wr_data; // [RQ11]
    end
  end

  // History is kept in every mode, so a bit carried over from
  // configuration mode shows no edge on entry to command mode [RQ10]
  always @(posedge sys_clk) begin
    if (rst) begin
      prev_cmd_reg <= 16'h0000;
      mode_cfg_reg <= 1'b0;
    end else if (image_done) begin
      prev_cmd_reg <= cmd0;
      mode_cfg_reg <= cmd0[`MCD_B_MODE]; // [RQ12]
    end
  end

  // Both presets share one value register; if both rise the value is the same
  always @(posedge sys_clk) begin
    if (rst) begin
      preset_encoder <= 1'b0;
      preset_motor   <= 1'b0;
      preset_value   <= 32'h0000_0000;
    end else begin
      preset_encoder <= go_preset_enc; // [RQ13]
      preset_motor   <= go_preset_pos; // [RQ19]
      if (go_preset_enc || go_preset_pos) begin
        preset_value <= param_value; // [RQ13] [RQ19]
      end
    end
  end

  // Fault clearing and segment programming are plain one-cycle pulses
  always @(posedge sys_clk) begin
    if (rst) begin
      clear_faults      <= 1'b0;
      program_segments  <= 1'b0;
      readback_segments <= 1'b0;
    end else begin
      clear_faults      <= go_clr_faults; // [RQ18]
      program_segments  <= go_program;    // [RQ17]
      readback_segments <= go_readback;   // [RQ17]
    end
  end

  // Segmented move start; type and direction stand until the next run
  always @(posedge sys_clk) begin
    if (rst) begin
      run_segmented_motion <= 1'b0;
      seg_dwell            <= 1'b0;
      seg_counterclockwise <= 1'b0;
    end else begin
      run_segmented_motion <= go_run_seg; // [RQ14]
      if (go_run_seg) begin
        seg_dwell            <= cmd1[`MCD_S_SEG_TYPE];  // [RQ14]
        seg_counterclockwise <= cmd1[`MCD_S_REV_BLEND]; // [RQ16]
      end
    end
  end

  // Manual bits start moves on an edge, but under gearing they are enables
  // and must stand between updates, or the motor would stop following the
  // encoder one cycle after each write. Losing the setup drops them.
  always @(posedge sys_clk) begin
    if (rst) begin
      manual_run_clockwise        <= 1'b0;
      manual_run_counterclockwise <= 1'b0;
      gearing_enable              <= 1'b0;
    end else if (accept) begin
      gearing_enable <= cmd1[`MCD_S_GEARING]; // [RQ21]
      if (cmd1[`MCD_S_GEARING]) begin
        manual_run_clockwise        <= cmd0[`MCD_B_RUN_CW];  // [RQ21]
        manual_run_counterclockwise <= cmd0[`MCD_B_RUN_CCW]; // [RQ21]
      end else begin
        manual_run_clockwise        <= go_run_cw;  // [RQ23]
        manual_run_counterclockwise <= go_run_ccw; // [RQ20]
      end
    end else if (!gearing_enable || !cfg_valid) begin
      manual_run_clockwise        <= 1'b0;
      manual_run_counterclockwise <= 1'b0;
    end
  end

  // Kind of the last move started; a manual start outranks a segment run
  always @(posedge sys_clk) begin
    if (rst) begin
      move_kind <= `MCD_MV_IDLE;
    end else if (!cmd1[`MCD_S_GEARING] && (go_run_cw || go_run_ccw)) begin
      if (follower_sel) begin
        move_kind <= `MCD_MV_FOLLOWER; // [RQ22]
      end else if (cmd1[`MCD_S_REG_MOVE]) begin
        move_kind <= `MCD_MV_REGISTER; // [RQ20]
      end else begin
        move_kind <= `MCD_MV_MANUAL;
      end
    end else if (go_run_seg) begin
      move_kind <= cmd1[`MCD_S_SEG_TYPE] ? `MCD_MV_DWELL : `MCD_MV_BLEND; // [RQ14]
    end
  end

  // Set wins over clear when both land together [RQ18] [RQ19]
  always @(posedge sys_clk) begin
    if (rst) begin
      move_done <= 1'b0;
    end else if (move_done_set) begin
      move_done <= 1'b1;
    end else if (go_clr_faults || go_preset_pos) begin
      move_done <= 1'b0; // [RQ18] [RQ19]
    end
  end

  // Dwell pause timer: loaded from word 9 at the start of a dwell move,
  // ticks once when the count runs out; only the next dwell run reloads it
  always @(posedge sys_clk) begin
    if (rst) begin
      dwell_left_reg <= 16'h0000;
      ms_cnt_reg     <= 16'h0000;
      dwell_run_reg  <= 1'b0;
      seg_pause_tick <= 1'b0;
    end else begin
      seg_pause_tick <= 1'b0;
      if (run_segmented_motion && seg_dwell) begin
        dwell_left_reg <= image_reg[9]; // [RQ15]
        ms_cnt_reg     <= 16'h0000;
        dwell_run_reg  <= 1'b1;
      end else if (dwell_run_reg) begin
        if (dwell_left_reg == 16'h0000) begin
          dwell_run_reg  <= 1'b0;
          seg_pause_tick <= 1'b1; // [RQ15]
        end else if (ms_cnt_reg == `MCD_MS_CYCLES - 1) begin
          ms_cnt_reg     <= 16'h0000;
          dwell_left_reg <= dwell_left_reg - 16'h0001;
        end else begin
          ms_cnt_reg <= ms_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Input image: status word and motor enable follow the setup
  always @(posedge sys_clk) begin
    if (rst) begin
      status_word  <= `MCD_STATUS_CFG_ERR;
      motor_enable <= 1'b0;
    end else begin
      status_word  <= cfg_valid ? {mode_cfg_reg, fault_active, 5'h00, move_done, 8'h00}
                                : `MCD_STATUS_CFG_ERR; // [RQ2]
      motor_enable <= cfg_valid && !fault_active; // [RQ2]
    end
  end

  // Out-of-span only matters while positions return in multi-word form
  always @(posedge sys_clk) begin
    if (rst) begin
      position_overflow <= 1'b0;
    end else begin
      position_overflow <= (mpos_ovf || epos_ovf) && !cfg_in_binary; // [RQ4]
    end
  end

  // Returned words in the configured format; unused indices read as zero
  always @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else begin
      case (rd_index)
        3'h0: rd_data <= status_word;
        3'h1: rd_data <= mpos_first;
        3'h2: rd_data <= mpos_second;
        3'h3: rd_data <= epos_first;
        3'h4: rd_data <= epos_second;
        default: rd_data <= 16'h0000;
      endcase
    end
  end

endmodule

// ---- bench/mcd_host_model.sv ----
/*
  Host model: writes the ten-word output image one word a cycle, then marks the update.
  Assumes the decoder samples its write port on the rising edge of sys_clk.
*/
`timescale 1ns/1ps
module mcd_host_model (
  input  wire logic        sys_clk,
  output logic             wr_en,
  output logic      [15:0] wr_addr,
  output logic      [15:0] wr_data,
  output logic             image_done
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
    image_done = 1'b0;
  end
  // Words 4 to 8 are sent as zero; no command under test reads them
  task automatic send(input logic [15:0] w0, w1, w2, w3, w9);
    integer i;
    for (i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      wr_en <= 1'b1;
      wr_addr <= 16'h0400 + 16'(i);
      wr_data <= (i == 0) ? w0 : (i == 1) ? w1 : (i == 2) ? w2 : (i == 3) ? w3 : (i == 9) ? w9 : 16'h0000;
    end
    @(negedge sys_clk);
    wr_en <= 1'b0;
    wr_data <= ~wr_data;
    image_done <= 1'b1;
    @(negedge sys_clk);
    image_done <= 1'b0;
  endtask
  // A zero image first, so every set bit of w0 is a fresh rising change
  task automatic cmd(input logic [15:0] w0, w1, w2, w3, w9);
    send(16'h0000, w1, w2, w3, w9);
    send(w0, w1, w2, w3, w9);
  endtask
endmodule

// ---- bench/mcd_decoder_assertions.sv ----
/*
  Checker for the motion command word decoder, bound to its ports.
  Assumes one clock, sys_clk, and the synchronous active-high rst.
*/
`timescale 1ns/1ps
module mcd_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        image_done,
  input wire logic        cfg_valid,
  input wire logic        cfg_in_binary,
  input wire logic        fault_active,
  input wire logic        move_done_set,
  input wire logic [31:0] motor_position,
  input wire logic [2:0]  rd_index,
  input wire logic [15:0] rd_data,
  input wire logic [15:0] status_word,
  input wire logic        motor_enable,
  input wire logic        move_done,
  input wire logic        preset_encoder,
  input wire logic        preset_motor,
  input wire logic        clear_faults,
  input wire logic        run_segmented_motion,
  input wire logic        seg_dwell,
  input wire logic        seg_pause_tick,
  input wire logic        position_overflow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire any_cmd = preset_encoder || preset_motor || clear_faults || run_segmented_motion;
  property p_cfg_status; !cfg_valid |=> status_word == 16'h6408; endproperty
  a_cfg_status: assert property (p_cfg_status) else $error("status not 6408h");
  property p_motor_en; 1'b1 |=> motor_enable == $past(cfg_valid && !fault_active); endproperty
  a_motor_en: assert property (p_motor_en) else $error("motor enable wrong");
  property p_cmd_cause; any_cmd |-> $past(image_done); endproperty
  a_cmd_cause: assert property (p_cmd_cause) else $error("command without update");
  property p_refused; image_done && !cfg_valid |=> !any_cmd; endproperty
  a_refused: assert property (p_refused) else $error("command while unconfigured");
  property p_one_shot; run_segmented_motion |=> !run_segmented_motion; endproperty
  a_one_shot: assert property (p_one_shot) else $error("run pulse too long");
  property p_done_set; move_done_set |=> move_done; endproperty
  a_done_set: assert property (p_done_set) else $error("move done not set");
  property p_done_clr; (clear_faults || preset_motor) && !$past(move_done_set) |-> !move_done; endproperty
  a_done_clr: assert property (p_done_clr) else $error("move done not cleared");
  property p_tick_dwell; seg_pause_tick |-> seg_dwell; endproperty
  a_tick_dwell: assert property (p_tick_dwell) else $error("pause tick in blend move");
  property p_ovf;
    !cfg_in_binary && ($signed(motor_position) > 32'sh01F3FFFF || $signed(motor_position) < -32'sh01F40000)
      |=> position_overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
  property p_rd_spare; rd_index > 3'h4 |=> rd_data == 16'h0000; endproperty
  a_rd_spare: assert property (p_rd_spare) else $error("spare input word not zero");
  c_run: cover property (run_segmented_motion);
  c_tick: cover property (seg_pause_tick);
  c_ovf: cover property (position_overflow);
endmodule
bind mcd_decoder mcd_checker u_chk (.sys_clk, .rst, .image_done, .cfg_valid, .cfg_in_binary, .fault_active,
  .move_done_set, .motor_position, .rd_index, .rd_data, .status_word, .motor_enable, .move_done, .preset_encoder,
  .preset_motor, .clear_faults, .run_segmented_motion, .seg_dwell, .seg_pause_tick, .position_overflow);

// ---- bench/testbench.sv ----
/*
  Self-checking bench for the motion command word decoder with a host model on its write port.
  Assumes a 20 MHz clock and a dwell count of 20000 cycles per millisecond.
*/
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0, rst = 1'b1, cfg_valid = 1'b0, cfg_in_binary = 1'b0, cfg_out_binary = 1'b0;
  logic        cfg_big_endian = 1'b0, fault_active = 1'b0, move_done_set = 1'b0;
  logic [31:0] motor_position = 32'h0000_0000, encoder_position = 32'h0000_000C, preset_value;
  logic [2:0]  rd_index = 3'h0, move_kind;
  logic [15:0] wr_addr, wr_data, rd_data, status_word;
  logic        wr_en, image_done, motor_enable, move_done, preset_encoder, preset_motor, clear_faults;
  logic        run_segmented_motion, seg_dwell, seg_counterclockwise, seg_pause_tick, program_segments;
  logic        readback_segments, manual_run_clockwise, manual_run_counterclockwise, gearing_enable;
  logic        position_overflow;
  logic [7:0]  seen = 8'h00;
  integer      n_mismatch = 0, comparisons = 0, b, n;
  logic [15:0] mw [5] = '{16'h0000, 16'h0080, 16'h1000, 16'h4000, 16'h1080};
  logic [2:0]  mk [5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h2};
  logic [15:0] pw [4][2] = '{'{16'hE21A, 16'hFEBF}, '{16'h04D2, 16'h0237}, '{16'hD687, 16'h0012}, '{16'hFF8B, 16'h344F}};
  logic [31:0] pv [4] = '{32'hFF8B344F, 32'h0012D687, 32'h0012D687, 32'hFF8B344F};
  logic [15:0] rw [3][2] = '{'{16'hE21A, 16'hFEBF}, '{16'h344F, 16'hFF8B}, '{16'hFF8B, 16'h344F}};

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) seen <= seen | {preset_encoder, run_segmented_motion, readback_segments, program_segments,
    clear_faults, preset_motor, manual_run_counterclockwise, manual_run_clockwise};

  mcd_host_model host (.sys_clk, .wr_en, .wr_addr, .wr_data, .image_done);
  mcd_decoder DUT (.sys_clk, .rst, .wr_en, .wr_addr, .wr_data, .image_done, .cfg_valid, .cfg_in_binary,
    .cfg_out_binary, .cfg_big_endian, .fault_active, .move_done_set, .motor_position, .encoder_position, .rd_index,
    .rd_data, .status_word, .motor_enable, .move_done, .preset_encoder, .preset_motor, .preset_value, .clear_faults,
    .run_segmented_motion, .seg_dwell, .seg_counterclockwise, .seg_pause_tick, .program_segments, .readback_segments,
    .manual_run_clockwise, .manual_run_counterclockwise, .move_kind, .gearing_enable, .position_overflow);

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic go(input logic [15:0] w0, w1, w2, w3, w9);
    seen = 8'h00;
    host.cmd(w0, w1, w2, w3, w9);
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] idx);
    rd_index = idx;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Generous margin over the roughly 21000 cycles the sequence needs
  initial begin
    #3_000_000;
    n_mismatch++;
    close_out;
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("status", 32'(status_word), 32'h6408);
    chk("motor_enable", 32'(motor_enable), 32'h0);
    go(16'h4000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk("refused", 32'(seen), 32'h0);
    cfg_valid = 1'b1;
    go(16'hC000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk("config mode", 32'(seen), 32'h0);
    host.send(16'h4000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    repeat (3) @(negedge sys_clk);
    chk("held bit", 32'(seen), 32'h0);
    for (b = 7; b < 15; b++) begin
      go(16'h0001 << b, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      chk("command bit", 32'(seen), 32'h1 << (b - 7));
    end
    for (b = 0; b < 5; b++) begin
      go(16'h0080, mw[b], 16'h0000, 16'h0000, 16'h0000);
      chk("move kind", 32'(move_kind), 32'(mk[b]));
    end
    go(16'h2000, 16'h0010, 16'h0000, 16'h0000, 16'h0000);
    chk("blend", {28'h0, seg_counterclockwise, move_kind}, 32'hC);
    go(16'h2000, 16'h0200, 16'h0000, 16'h0000, 16'h0001);
    chk("dwell", {28'h0, seg_dwell, move_kind}, 32'hD);
    n = 3;
    while (seg_pause_tick !== 1'b1 && n < 21000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("dwell time", 32'(n >= 19998 && n <= 20004), 32'h1);
    go(16'h0080, 16'h0040, 16'h0000, 16'h0000, 16'h0000);
    chk("gearing", {30'h0, gearing_enable, manual_run_clockwise}, 32'h3);
    go(16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0000);
    chk("gear off", 32'(manual_run_clockwise), 32'h0);
    for (b = 0; b < 4; b++) begin
      cfg_out_binary = (b > 1);
      cfg_big_endian = (b == 3);
      go(16'h0200, 16'h0000, pw[b][0], pw[b][1], 16'h0000);
      chk("preset", preset_value, pv[b]);
    end
    motor_position = 32'hFF8B344F;
    for (b = 0; b < 3; b++) begin
      cfg_in_binary = (b > 0);
      cfg_big_endian = (b == 2);
      rd(3'h1);
      chk("pos first", 32'(rd_data), 32'(rw[b][0]));
      rd(3'h2);
      chk("pos second", 32'(rd_data), 32'(rw[b][1]));
    end
    cfg_in_binary = 1'b0;
    rd(3'h4);
    chk("encoder", 32'(rd_data), 32'hC);
    rd(3'h3);
    chk("encoder hi", 32'(rd_data), 32'h0);
    rd(3'h5);
    chk("spare", 32'(rd_data), 32'h0);
    motor_position = 32'h01F40000;
    rd(3'h0);
    chk("overflow", 32'(position_overflow), 32'h1);
    motor_position = 32'h01F3FFFF;
    rd(3'h0);
    chk("in span", 32'(position_overflow), 32'h0);
    for (b = 0; b < 2; b++) begin
      move_done_set = 1'b1;
      @(negedge sys_clk);
      move_done_set = 1'b0;
      @(negedge sys_clk);
      chk("done set", 32'(move_done), 32'h1);
      go(b ? 16'h0200 : 16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      chk("done clear", 32'(move_done), 32'h0);
    end
    chk("motor on", 32'(motor_enable), 32'h1);
    fault_active = 1'b1;
    rd(3'h0);
    chk("fault off", 32'(motor_enable), 32'h0);
    chk("status fault", 32'(status_word), 32'h4000);
    close_out;
  end
endmodule
